// ===== far_end_model.sv
`timescale 1ns/1ps
// Far side: receiver events, shifter loads, timer and external clocks
module far_end_model (
    input wire logic mclk,
    output uart_flags_pkg::rx_event_type rx_event,
    output logic tx_load,
    output logic timer_underflow,
    output logic ext_serial_clock_pin
);
    logic [6:0] cnt;
    initial begin
        rx_event = '0;
        tx_load = 1'b0;
        cnt = 7'h00;
    end
    // Timer period 2 cycles, external period 128 cycles (below 2 MHz)
    always @(posedge mclk) begin
        cnt <= cnt + 7'h01;
        timer_underflow <= cnt[0];
        ext_serial_clock_pin <= cnt[6];
    end
    // Done pulse at stop bit or last data bit, data inverted after it
    task automatic frame(input logic [7:0] d, input logic [2:0] er);
        @(posedge mclk);
        rx_event <= {1'b1, er, d};
        @(posedge mclk);
        rx_event <= {1'b0, 3'h0, ~d};
    endtask : frame
    task automatic shift_out();
        @(posedge mclk);
        tx_load <= 1'b1;
        @(posedge mclk);
        tx_load <= 1'b0;
    endtask : shift_out
endmodule : far_end_model

// ===== uart_flags_pkg.sv
package uart_flags_pkg;
    // Register byte addresses
    localparam logic [3:0] data_ofs = 4'h0;
    localparam logic [3:0] status_ofs = 4'h4;
    localparam logic [3:0] mode_ofs = 4'h8;
    localparam logic [3:0] iosvc_ofs = 4'hC;
    // Status word field positions
    localparam int parity_err_pos = 7;
    localparam int overrun_err_pos = 6;
    localparam int framing_err_pos = 5;
    localparam int rx_full_pos = 4;
    localparam int tx_empty_pos = 3;
    localparam int rx_irq_en_pos = 1;
    localparam int tx_irq_en_pos = 0;
    localparam int err_clear_pos = 8;
    // Mode word field positions
    localparam int cs_pos = 0;
    localparam int md_pos = 4;
    // Operating modes
    localparam logic [1:0] mode_async = 2'h0;
    localparam logic [1:0] mode_multi = 2'h1;
    localparam logic [1:0] mode_sync = 2'h2;
    // Clock source codes
    localparam logic [2:0] cs_max_gen = 3'h4;
    localparam logic [2:0] cs_timer = 3'h6;
    localparam logic [2:0] cs_ext = 3'h7;
    // Divider ratios
    localparam logic [5:0] timer_div_sync = 6'h02;
    localparam logic [5:0] timer_div_async = 6'h20;
    localparam logic [5:0] ext_div_async = 6'h10;
    // Reset values
    localparam logic [2:0] cs_rst = 3'h0;
    localparam logic [1:0] mode_rst = 2'h0;
    localparam logic [7:0] rdata_rst = 8'h00;
    localparam logic [7:0] tdata_rst = 8'h00;
    // Largest external clock frequency in MHz
    localparam int ext_clk_max_mhz = 2;

    typedef struct packed {
        logic done;
        logic par_err;
        logic ovr_err;
        logic frm_err;
        logic [7:0] data;
    } rx_event_type;

    typedef struct packed {
        logic [7:0] rx_data_buffer;
        logic [7:0] tx_data_buffer;
        logic rx_full_flag;
        logic tx_empty_flag;
        logic parity_err_flag;
        logic overrun_err_flag;
        logic framing_err_flag;
        logic rx_irq_enable;
        logic tx_irq_enable;
        logic [2:0] clock_source_field;
        logic [1:0] mode;
        logic iosvc_active;
        logic [5:0] div_cnt;
        logic [4:0] gen_cnt;
        logic tmr_q;
        logic ext_q;
        logic bit_clk_en;
        logic [31:0] rdata;
        logic rvalid;
    } state_type;
endpackage : uart_flags_pkg

// ===== uart_irq_flags_baud_select.sv
`timescale 1ns/1ps
module uart_irq_flags_baud_select (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire uart_flags_pkg::rx_event_type rx_event,
    input wire logic tx_load,
    input wire logic prescaler_tick,
    input wire logic timer_underflow,
    input wire logic ext_serial_clock_pin,
    output logic [7:0] tx_data,
    output logic bit_clk_en,
    output logic invalid_data,
    output logic rx_irq,
    output logic tx_irq,
    output logic iosvc_start,
    output logic iosvc_active
);
    uart_flags_pkg::state_type s_ff;
    uart_flags_pkg::state_type nxt_s;
    logic rd_acc;
    logic wr_acc;
    logic any_err;
    logic rx_req;
    logic tx_req;

    ////////////////////////////////////////////////////////////////////////
    // Bus access and request terms
    assign rd_acc = read && !s_ff.rvalid;
    assign wr_acc = write;
    assign waitrequest = read && !s_ff.rvalid;
    assign readdata = s_ff.rdata;
    assign any_err = s_ff.parity_err_flag | s_ff.overrun_err_flag | s_ff.framing_err_flag;
    assign rx_req = s_ff.rx_irq_enable && (s_ff.rx_full_flag || any_err);
    assign tx_req = s_ff.tx_irq_enable && s_ff.tx_empty_flag;
    assign rx_irq = rx_req;
    assign tx_irq = tx_req;
    assign invalid_data = any_err;
    assign tx_data = s_ff.tx_data_buffer;
    assign bit_clk_en = s_ff.bit_clk_en;
    assign iosvc_active = s_ff.iosvc_active;
    assign iosvc_start = (rx_req || tx_req) && !s_ff.iosvc_active && !any_err;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [5:0] ratio;
        logic src_tick;
        logic [4:0] gen_lim;
        ratio = 6'h01;
        src_tick = 1'b0;
        gen_lim = 5'h00;
        nxt_s = s_ff;
        nxt_s.rvalid = 1'b0;
        nxt_s.bit_clk_en = 1'b0;
        nxt_s.tmr_q = timer_underflow;
        nxt_s.ext_q = ext_serial_clock_pin;
        // Receive side
        if (rx_event.done) begin
            nxt_s.rx_data_buffer = rx_event.data;
            nxt_s.rx_full_flag = 1'b1;
            nxt_s.overrun_err_flag = s_ff.overrun_err_flag | rx_event.ovr_err | s_ff.rx_full_flag;
            if (s_ff.mode != uart_flags_pkg::mode_sync) begin
                nxt_s.framing_err_flag = s_ff.framing_err_flag | rx_event.frm_err;
            end
            if (s_ff.mode == uart_flags_pkg::mode_async) begin
                nxt_s.parity_err_flag = s_ff.parity_err_flag | rx_event.par_err;
            end
        end
        // Transmit side
        if (tx_load) begin
            nxt_s.tx_empty_flag = 1'b1;
        end
        // Register reads
        if (rd_acc) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata = 32'h0000_0000;
            case (address)
                uart_flags_pkg::data_ofs: begin
                    nxt_s.rdata[7:0] = s_ff.rx_data_buffer;
                    if (!rx_event.done) begin
                        nxt_s.rx_full_flag = 1'b0;
                    end
                end
                uart_flags_pkg::status_ofs: begin
                    nxt_s.rdata[uart_flags_pkg::parity_err_pos] = s_ff.parity_err_flag;
                    nxt_s.rdata[uart_flags_pkg::overrun_err_pos] = s_ff.overrun_err_flag;
                    nxt_s.rdata[uart_flags_pkg::framing_err_pos] = s_ff.framing_err_flag;
                    nxt_s.rdata[uart_flags_pkg::rx_full_pos] = s_ff.rx_full_flag;
                    nxt_s.rdata[uart_flags_pkg::tx_empty_pos] = s_ff.tx_empty_flag;
                    nxt_s.rdata[uart_flags_pkg::rx_irq_en_pos] = s_ff.rx_irq_enable;
                    nxt_s.rdata[uart_flags_pkg::tx_irq_en_pos] = s_ff.tx_irq_enable;
                    nxt_s.rdata[uart_flags_pkg::err_clear_pos] = 1'b1;
                end
                uart_flags_pkg::mode_ofs: begin
                    nxt_s.rdata[uart_flags_pkg::cs_pos +: 3] = s_ff.clock_source_field;
                    nxt_s.rdata[uart_flags_pkg::md_pos +: 2] = s_ff.mode;
                end
                uart_flags_pkg::iosvc_ofs: begin
                    nxt_s.rdata[0] = s_ff.iosvc_active;
                end
                default: begin
                    nxt_s.rdata = 32'h0000_0000;
                end
            endcase
        end
        // Register writes
        if (wr_acc) begin
            case (address)
                uart_flags_pkg::data_ofs: begin
                    nxt_s.tx_data_buffer = writedata[7:0];
                    if (!tx_load) begin
                        nxt_s.tx_empty_flag = 1'b0;
                    end
                end
                uart_flags_pkg::status_ofs: begin
                    nxt_s.rx_irq_enable = writedata[uart_flags_pkg::rx_irq_en_pos];
                    nxt_s.tx_irq_enable = writedata[uart_flags_pkg::tx_irq_en_pos];
                    if (!writedata[uart_flags_pkg::err_clear_pos] && !rx_event.done) begin
                        nxt_s.parity_err_flag = 1'b0;
                        nxt_s.overrun_err_flag = 1'b0;
                        nxt_s.framing_err_flag = 1'b0;
                    end
                end
                uart_flags_pkg::mode_ofs: begin
                    nxt_s.clock_source_field = writedata[uart_flags_pkg::cs_pos +: 3];
                    nxt_s.mode = writedata[uart_flags_pkg::md_pos +: 2];
                end
                uart_flags_pkg::iosvc_ofs: begin
                    nxt_s.iosvc_active = writedata[0] && !any_err;
                end
                default: begin
                end
            endcase
        end
        // Intelligent io service
        if (iosvc_start) begin
            nxt_s.iosvc_active = 1'b1;
        end
        if (any_err) begin
            nxt_s.iosvc_active = 1'b0;
        end
        // Bit clock selection
        if (s_ff.clock_source_field == uart_flags_pkg::cs_timer) begin
            src_tick = timer_underflow && !s_ff.tmr_q;
            ratio = (s_ff.mode == uart_flags_pkg::mode_sync) ? uart_flags_pkg::timer_div_sync
                                                              : uart_flags_pkg::timer_div_async;
        end else if (s_ff.clock_source_field == uart_flags_pkg::cs_ext) begin
            src_tick = ext_serial_clock_pin && !s_ff.ext_q;
            ratio = (s_ff.mode == uart_flags_pkg::mode_sync) ? 6'h01 : uart_flags_pkg::ext_div_async;
        end else if (s_ff.clock_source_field <= uart_flags_pkg::cs_max_gen) begin
            gen_lim = 5'((6'h02 << s_ff.clock_source_field) - 6'h01);
            if (prescaler_tick) begin
                if (s_ff.gen_cnt >= gen_lim) begin
                    nxt_s.gen_cnt = 5'h00;
                    src_tick = 1'b1;
                end else begin
                    nxt_s.gen_cnt = s_ff.gen_cnt + 5'h01;
                end
            end
        end
        if (src_tick) begin
            if (s_ff.div_cnt + 6'h01 >= ratio) begin
                nxt_s.div_cnt = 6'h00;
                nxt_s.bit_clk_en = 1'b1;
            end else begin
                nxt_s.div_cnt = s_ff.div_cnt + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_ff <= '0;
            s_ff.tx_empty_flag <= 1'b1;
            s_ff.clock_source_field <= uart_flags_pkg::cs_rst;
            s_ff.mode <= uart_flags_pkg::mode_rst;
            s_ff.rx_data_buffer <= uart_flags_pkg::rdata_rst;
            s_ff.tx_data_buffer <= uart_flags_pkg::tdata_rst;
        end else begin
            s_ff <= nxt_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence rx_err_seq;
        rx_event.done && rx_event.ovr_err;
    endsequence

    sequence data_read_seq;
        rd_acc && address == uart_flags_pkg::data_ofs;
    endsequence

    sequence data_write_seq;
        wr_acc && address == uart_flags_pkg::data_ofs;
    endsequence

    sequence ext_sync_edge_seq;
        s_ff.clock_source_field == uart_flags_pkg::cs_ext && s_ff.mode == uart_flags_pkg::mode_sync
            && ext_serial_clock_pin && !s_ff.ext_q;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Receive checks
    a_rx_irq_level: assert property (@(posedge mclk) disable iff (rst)
        s_ff.rx_irq_enable && rx_event.done && !(wr_acc && address == uart_flags_pkg::status_ofs) |=> rx_irq)
        else $error("rx irq missing");
    a_rx_irq_hold: assert property (@(posedge mclk) disable iff (rst)
        rx_irq && !(rd_acc && address == uart_flags_pkg::data_ofs)
            && !(wr_acc && address == uart_flags_pkg::status_ofs) |=> rx_irq)
        else $error("rx irq dropped");
    a_full_on_store: assert property (@(posedge mclk) disable iff (rst)
        rx_event.done |=> s_ff.rx_full_flag && s_ff.rx_data_buffer == $past(rx_event.data))
        else $error("no store");
    a_err_with_full: assert property (@(posedge mclk) disable iff (rst)
        rx_err_seq |=> s_ff.overrun_err_flag && s_ff.rx_full_flag)
        else $error("error order");
    a_invalid_data: assert property (@(posedge mclk) disable iff (rst)
        rx_err_seq |=> invalid_data)
        else $error("data not marked invalid");
    a_parity_async: assert property (@(posedge mclk) disable iff (rst)
        rx_event.done && rx_event.par_err && s_ff.mode == uart_flags_pkg::mode_async |=> s_ff.parity_err_flag)
        else $error("parity not set");
    a_frame_async: assert property (@(posedge mclk) disable iff (rst)
        rx_event.done && rx_event.frm_err && s_ff.mode != uart_flags_pkg::mode_sync |=> s_ff.framing_err_flag)
        else $error("framing not set");
    a_no_parity_m1: assert property (@(posedge mclk) disable iff (rst)
        s_ff.mode != uart_flags_pkg::mode_async && !s_ff.parity_err_flag |=> !s_ff.parity_err_flag)
        else $error("parity set");
    a_no_frame_sync: assert property (@(posedge mclk) disable iff (rst)
        s_ff.mode == uart_flags_pkg::mode_sync && !s_ff.framing_err_flag |=> !s_ff.framing_err_flag)
        else $error("framing set");
    a_overrun_full: assert property (@(posedge mclk) disable iff (rst)
        rx_event.done && s_ff.rx_full_flag |=> s_ff.overrun_err_flag)
        else $error("overrun not set");
    a_read_clears: assert property (@(posedge mclk) disable iff (rst)
        rd_acc && address == uart_flags_pkg::data_ofs && !rx_event.done |=> !s_ff.rx_full_flag)
        else $error("full not cleared");
    a_full_stays: assert property (@(posedge mclk) disable iff (rst)
        s_ff.rx_full_flag && !(rd_acc && address == uart_flags_pkg::data_ofs) |=> s_ff.rx_full_flag)
        else $error("full lost");
    a_err_clear: assert property (@(posedge mclk) disable iff (rst)
        wr_acc && address == uart_flags_pkg::status_ofs && !writedata[uart_flags_pkg::err_clear_pos]
            && !rx_event.done |=> !any_err)
        else $error("errors kept");
    a_data_read: assert property (@(posedge mclk) disable iff (rst)
        data_read_seq |=> readdata[7:0] == $past(s_ff.rx_data_buffer))
        else $error("rx data not returned");

    ////////////////////////////////////////////////////////////////////////
    // Transmit, service and clock checks
    a_empty_write: assert property (@(posedge mclk) disable iff (rst)
        wr_acc && address == uart_flags_pkg::data_ofs && !tx_load |=> !s_ff.tx_empty_flag)
        else $error("empty kept");
    a_empty_on_load: assert property (@(posedge mclk) disable iff (rst)
        tx_load |=> s_ff.tx_empty_flag)
        else $error("empty not set");
    a_empty_stays: assert property (@(posedge mclk) disable iff (rst)
        !s_ff.tx_empty_flag && !tx_load |=> !s_ff.tx_empty_flag)
        else $error("empty set early");
    a_tx_irq_level: assert property (@(posedge mclk) disable iff (rst)
        s_ff.tx_irq_enable && tx_load && !(wr_acc && address == uart_flags_pkg::status_ofs) |=> tx_irq)
        else $error("tx irq missing");
    a_tx_irq_hold: assert property (@(posedge mclk) disable iff (rst)
        tx_irq && !(wr_acc && (address == uart_flags_pkg::data_ofs || address == uart_flags_pkg::status_ofs))
        |=> tx_irq)
        else $error("tx irq dropped");
    a_data_write: assert property (@(posedge mclk) disable iff (rst)
        data_write_seq |=> tx_data == $past(writedata[7:0]))
        else $error("tx data not loaded");
    a_iosvc_stop: assert property (@(posedge mclk) disable iff (rst)
        any_err |=> !s_ff.iosvc_active)
        else $error("service not stopped");
    a_svc_start: assert property (@(posedge mclk) disable iff (rst)
        (rx_irq || tx_irq) && !iosvc_active && !any_err |=> iosvc_active)
        else $error("service not started");
    a_bit_clk_pulse: assert property (@(posedge mclk) disable iff (rst)
        bit_clk_en && $stable(s_ff.clock_source_field) |=> !bit_clk_en)
        else $error("bit clock too long");
    a_ext_sync_edge: assert property (@(posedge mclk) disable iff (rst)
        ext_sync_edge_seq |=> bit_clk_en)
        else $error("ext edge not passed");
endmodule : uart_irq_flags_baud_select

// ===== uart_irq_flags_baud_select_bench.sv
`timescale 1ns/1ps
module uart_irq_flags_baud_select_bench;
    logic mclk, rst, read, write, prescaler_tick, waitrequest, tx_load;
    logic timer_underflow, ext_serial_clock_pin, bit_clk_en, invalid_data;
    logic rx_irq, tx_irq, iosvc_start, iosvc_active;
    logic [3:0] address;
    logic [31:0] writedata, readdata, d;
    logic [7:0] tx_data;
    uart_flags_pkg::rx_event_type rx_event;
    int failures, cmp_count;
    uart_irq_flags_baud_select i_uart_irq_flags_baud_select (.mclk(mclk), .rst(rst),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .rx_event(rx_event),
        .tx_load(tx_load), .prescaler_tick(prescaler_tick), .timer_underflow(timer_underflow),
        .ext_serial_clock_pin(ext_serial_clock_pin), .tx_data(tx_data),
        .bit_clk_en(bit_clk_en), .invalid_data(invalid_data), .rx_irq(rx_irq),
        .tx_irq(tx_irq), .iosvc_start(iosvc_start), .iosvc_active(iosvc_active));
    far_end_model i_far_end_model (.mclk(mclk), .rx_event(rx_event), .tx_load(tx_load),
        .timer_underflow(timer_underflow), .ext_serial_clock_pin(ext_serial_clock_pin));
    always #2 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic bus_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        address <= a;
        writedata <= v;
        write <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        address <= a;
        read <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        v = readdata;
        read <= 1'b0;
    endtask : bus_read
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask : chk_bit
    task automatic tally_and_finish();
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////
    // Receive one frame in a mode, read flags, data, then clear errors
    task automatic rx_case(input logic [1:0] md, input logic [2:0] er, input logic [31:0] e);
        bus_write(uart_flags_pkg::mode_ofs, {26'h0, md, 4'h0});
        bus_write(uart_flags_pkg::status_ofs, 32'h102);
        i_far_end_model.frame(8'hA5, er);
        bus_read(uart_flags_pkg::status_ofs, d);
        chk_word("status", e, d);
        chk_bit("invalid", |e[7:5], invalid_data);
        bus_read(uart_flags_pkg::data_ofs, d);
        chk_word("rx_data", 32'hA5, d);
        chk_bit("rx_irq_err", |e[7:5], rx_irq);
        bus_write(uart_flags_pkg::status_ofs, 32'h002);
        bus_read(uart_flags_pkg::status_ofs, d);
        chk_word("cleared", 32'h10A, d);
        chk_bit("rx_irq_clr", 1'b0, rx_irq);
    endtask : rx_case
    // Measure cycles between two bit clock pulses
    task automatic clk_case(input logic [1:0] md, input logic [2:0] cs, input int per);
        int n;
        bus_write(uart_flags_pkg::mode_ofs, {26'h0, md, 1'b0, cs});
        repeat (3) begin
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (bit_clk_en !== 1'b1);
        end
        chk_word("bit_period", per, n);
    endtask : clk_case
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        prescaler_tick = 1'b1;
        failures = 0;
        cmp_count = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        bus_read(uart_flags_pkg::status_ofs, d);
        chk_word("status_rst", 32'h108, d);
        bus_read(4'h2, d);
        chk_word("unmapped", 32'h0, d);
        rx_case(uart_flags_pkg::mode_async, 3'b100, 32'h19A);
        rx_case(uart_flags_pkg::mode_async, 3'b001, 32'h13A);
        rx_case(uart_flags_pkg::mode_multi, 3'b110, 32'h15A);
        rx_case(uart_flags_pkg::mode_sync, 3'b101, 32'h11A);
        rx_case(uart_flags_pkg::mode_sync, 3'b010, 32'h15A);
        bus_write(uart_flags_pkg::status_ofs, 32'h101);
        @(negedge mclk);
        chk_bit("tx_irq_rst", 1'b1, tx_irq);
        bus_write(uart_flags_pkg::data_ofs, 32'h3C);
        @(negedge mclk);
        chk_bit("tx_irq_wr", 1'b0, tx_irq);
        chk_word("tx_data", 32'h3C, {24'h0, tx_data});
        bus_read(uart_flags_pkg::data_ofs, d);
        chk_word("shared_addr", 32'hA5, d);
        i_far_end_model.shift_out();
        @(negedge mclk);
        chk_bit("tx_irq_load", 1'b1, tx_irq);
        for (int c = 0; c < 5; c++) begin
            clk_case(uart_flags_pkg::mode_sync, 3'(c), 2 << c);
        end
        clk_case(uart_flags_pkg::mode_sync, 3'h6, 4);
        clk_case(uart_flags_pkg::mode_async, 3'h6, 64);
        clk_case(uart_flags_pkg::mode_sync, 3'h7, 128);
        clk_case(uart_flags_pkg::mode_async, 3'h7, 2048);
        bus_write(uart_flags_pkg::iosvc_ofs, 32'h1);
        @(negedge mclk);
        chk_bit("svc_on", 1'b1, iosvc_active);
        i_far_end_model.frame(8'h5A, 3'b010);
        @(posedge mclk);
        @(negedge mclk);
        chk_bit("svc_off", 1'b0, iosvc_active);
        chk_bit("svc_blocked", 1'b0, iosvc_start);
        bus_write(uart_flags_pkg::status_ofs, 32'h001);
        @(negedge mclk);
        chk_bit("svc_restart", 1'b1, iosvc_start);
        i_far_end_model.frame(8'h11, 3'b000);
        i_far_end_model.frame(8'h22, 3'b000);
        bus_read(uart_flags_pkg::status_ofs, d);
        chk_word("overrun_full", 32'h159, d);
        tally_and_finish();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        failures++;
        tally_and_finish();
    end
endmodule : uart_irq_flags_baud_select_bench
